// >>> hw/tal_alert_top.sv
// temperature limit alert logic with smbus alert-response slave
//
// Notes on behaviour
// - conversion reads local then remote, 31.25 ms
// - slower rates add idle gap only
// - mask bit zero enables alert output
// - compare readings with limits, set status
// - unmasked alert status bits pull alert low
// - comparator mode releases when condition clears
// - comparator mode bit, cleared at reset
// - interrupt mode status read sets mask
// - status read clears, resets on persisting condition
// - interrupt mode when comparator bit low
// - ara answers own address, then masks
// - check each sent bit on data line
// - alert response address is 0001100
// - answer ara only when config bit low
// - mask and alert config reset zero
// - slave only, never drives clock
// - select pin picks address 18 or 4e
// - bus low past timeout resets slave
// - diode fault alone never alerts
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "tal_params.svh"

module tal_alert_top #(
    parameter int CONV_CYCLES = `TAL_CONV_TIME_US * (`TAL_CLK_HZ / 1000000),
    parameter int TOUT_CYCLES = `TAL_TOUT_TIME_US * (`TAL_CLK_HZ / 1000000)
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // converter results
    input  wire logic [7:0] local_temp_in,
    input  wire logic [7:0] remote_temp_in,
    input  wire logic       diode_fault_in,
    output logic            conv_busy,
    // pins
    input  wire logic       slave_addr_select_pin,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            alert_out,
    output logic            alert_oe_n
);

    // ----------------------------------------------------------
    // declarations
    // ----------------------------------------------------------
    tal_pkg::tal_main_t r_reg;
    tal_pkg::tal_main_t r_next;
    logic               local_done;
    logic               remote_done;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_cond;
    logic               stop_cond;
    logic [6:0]         own_addr;
    logic [7:0]         own_byte;
    logic               comp_mode;
    logic               ara_ok;
    logic               alert_on;

    // signed greater-than used for all high and critical limits
    function automatic logic tal_gt(input logic [7:0] a, input logic [7:0] b);
        tal_gt = ($signed(a) > $signed(b));
    endfunction : tal_gt

    // ----------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------
    tal_conv_seq #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_seq (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .rate_code   (r_reg.rate[`TAL_RATE_W-1:0]),
        .local_done  (local_done),
        .remote_done (remote_done),
        .busy        (conv_busy)
    );

    // ----------------------------------------------------------
    // line events and decoded modes
    // ----------------------------------------------------------
    assign scl_rise   = r_reg.scl_s && !r_reg.scl_d;
    assign scl_fall   = !r_reg.scl_s && r_reg.scl_d;
    assign start_cond = r_reg.scl_s && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s;
    assign stop_cond  = r_reg.scl_s && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s;
    assign own_addr   = r_reg.a0_s ? `TAL_ADDR_HI : `TAL_ADDR_LO;
    assign own_byte   = {own_addr, 1'b0};
    assign comp_mode  = r_reg.fcm[`TAL_FCM_COMP_BIT];
    assign ara_ok     = !r_reg.fcm[`TAL_FCM_ARACFG_BIT] && r_reg.alert_drv;

    always_comb
    begin
        if (r_reg.cfg[`TAL_CFG_MASK_BIT])
            alert_on = 1'b0;  // masked
        else if (comp_mode)
            alert_on = |(r_reg.cmp & `TAL_ST_ALERT_BITS);
        else
            alert_on = |(r_reg.stat & `TAL_ST_ALERT_BITS);
    end

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;

        // two-flop synchronisers for pins
        r_next.scl_m = scl_in;
        r_next.scl_s = r_reg.scl_m;
        r_next.scl_d = r_reg.scl_s;
        r_next.sda_m = sda_in;
        r_next.sda_s = r_reg.sda_m;
        r_next.sda_d = r_reg.sda_s;
        r_next.a0_m  = slave_addr_select_pin;
        r_next.a0_s  = r_reg.a0_m;

        // register writes
        r_next.rdata = `TAL_RST_BYTE;
        if (reg_wr)
        begin
            case (reg_addr)
                `TAL_OFF_CONFIG: r_next.cfg  = reg_wdata;
                `TAL_OFF_FCM:    r_next.fcm  = reg_wdata;
                `TAL_OFF_RATE:   r_next.rate = reg_wdata;
                `TAL_OFF_LHL:    r_next.lhl  = reg_wdata;
                `TAL_OFF_RHL:    r_next.rhl  = reg_wdata;
                `TAL_OFF_RLL:    r_next.rll  = reg_wdata;
                `TAL_OFF_RCL:    r_next.rcl  = reg_wdata;
                default:         r_next.cfg  = r_reg.cfg;
            endcase
        end

        // register reads, data shown one cycle later
        if (reg_rd)
        begin
            case (reg_addr)
                `TAL_OFF_CONFIG: r_next.rdata = r_reg.cfg;
                `TAL_OFF_FCM:    r_next.rdata = r_reg.fcm;
                `TAL_OFF_STATUS:
                begin
                    r_next.rdata = r_reg.stat;
                    r_next.rdata[`TAL_ST_BUSY_BIT] = conv_busy;
                end
                `TAL_OFF_RATE:   r_next.rdata = r_reg.rate;
                `TAL_OFF_LHL:    r_next.rdata = r_reg.lhl;
                `TAL_OFF_RHL:    r_next.rdata = r_reg.rhl;
                `TAL_OFF_RLL:    r_next.rdata = r_reg.rll;
                `TAL_OFF_RCL:    r_next.rdata = r_reg.rcl;
                `TAL_OFF_LT:     r_next.rdata = r_reg.lt;
                `TAL_OFF_RT:     r_next.rdata = r_reg.rt;
                default:         r_next.rdata = `TAL_RST_BYTE;
            endcase
            if (reg_addr == `TAL_OFF_STATUS)
            begin
                r_next.stat = `TAL_RST_BYTE;
                if (!comp_mode && (|(r_reg.stat & `TAL_ST_ALERT_BITS)))
                    r_next.cfg[`TAL_CFG_MASK_BIT] = 1'b1;
            end
        end

        if (local_done)
        begin
            r_next.lt = local_temp_in;
            r_next.cmp[`TAL_ST_LHIGH_BIT] = tal_gt(local_temp_in, r_reg.lhl);
            if (tal_gt(local_temp_in, r_reg.lhl))
                r_next.stat[`TAL_ST_LHIGH_BIT] = 1'b1;
        end

        if (remote_done)
        begin
            r_next.rt = remote_temp_in;
            r_next.cmp[`TAL_ST_RHIGH_BIT] = tal_gt(remote_temp_in, r_reg.rhl);
            r_next.cmp[`TAL_ST_RLOW_BIT]  = tal_gt(r_reg.rll, remote_temp_in);
            r_next.cmp[`TAL_ST_RCRIT_BIT] = tal_gt(remote_temp_in, r_reg.rcl);
            // set wins over a same-cycle read clear
            r_next.stat = r_next.stat | (r_next.cmp & `TAL_ST_ALERT_BITS);
            if (diode_fault_in)
                r_next.stat[`TAL_ST_OPEN_BIT] = 1'b1;
        end

        if (r_reg.scl_s && r_reg.sda_s)
            r_next.tout = '0;
        else if (r_reg.tout != `TAL_CNT_W'(TOUT_CYCLES))
            r_next.tout = r_reg.tout + 1'b1;

        // smbus slave, alert response only
        case (r_reg.smb)
            tal_pkg::TAL_SMB_IDLE:
            begin
                r_next.drive = 1'b0;
            end
            tal_pkg::TAL_SMB_ADDR:
            begin
                if (scl_rise)
                begin
                    r_next.sh   = {r_reg.sh[6:0], r_reg.sda_s};
                    r_next.bcnt = r_reg.bcnt + 1'b1;
                end
                else if (scl_fall && (r_reg.bcnt == `TAL_BITS_BYTE))
                begin
                    if ((r_reg.sh == {`TAL_ARA_ADDR, 1'b1}) && ara_ok)
                    begin
                        r_next.smb   = tal_pkg::TAL_SMB_ACK;
                        r_next.drive = 1'b1;
                    end
                    else
                    begin
                        r_next.smb = tal_pkg::TAL_SMB_IDLE;
                    end
                end
            end
            tal_pkg::TAL_SMB_ACK:
            begin
                if (scl_fall)
                begin
                    r_next.smb   = tal_pkg::TAL_SMB_SEND;
                    r_next.bcnt  = '0;
                    r_next.sh    = own_byte;
                    r_next.drive = !own_byte[7];
                end
            end
            tal_pkg::TAL_SMB_SEND:
            begin
                if (scl_rise)
                begin
                    if (r_reg.sda_s != r_reg.sh[7])
                    begin
                        r_next.smb   = tal_pkg::TAL_SMB_IDLE;
                        r_next.drive = 1'b0;
                    end
                    else
                    begin
                        r_next.bcnt = r_reg.bcnt + 1'b1;
                    end
                end
                else if (scl_fall)
                begin
                    if (r_reg.bcnt == `TAL_BITS_BYTE)
                    begin
                        // whole address sent, mask and release
                        r_next.smb   = tal_pkg::TAL_SMB_NACK;
                        r_next.drive = 1'b0;
                        r_next.cfg[`TAL_CFG_MASK_BIT] = 1'b1;
                    end
                    else
                    begin
                        r_next.sh    = {r_reg.sh[6:0], 1'b0};
                        r_next.drive = !r_reg.sh[6];
                    end
                end
            end
            tal_pkg::TAL_SMB_NACK:
            begin
                r_next.drive = 1'b0;  // master nack, then stop
            end
            default:
            begin
                r_next.smb   = tal_pkg::TAL_SMB_IDLE;
                r_next.drive = 1'b0;
            end
        endcase

        // start and stop override any state
        if (start_cond)
        begin
            r_next.smb   = tal_pkg::TAL_SMB_ADDR;
            r_next.bcnt  = '0;
            r_next.drive = 1'b0;
        end
        else if (stop_cond)
        begin
            r_next.smb   = tal_pkg::TAL_SMB_IDLE;
            r_next.drive = 1'b0;
        end

        if (r_reg.tout == `TAL_CNT_W'(TOUT_CYCLES))
        begin
            r_next.smb   = tal_pkg::TAL_SMB_IDLE;
            r_next.drive = 1'b0;
        end

        r_next.alert_drv = alert_on && !r_next.cfg[`TAL_CFG_MASK_BIT];
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg       <= '0;
            r_reg.scl_m <= 1'b1;
            r_reg.scl_s <= 1'b1;
            r_reg.scl_d <= 1'b1;
            r_reg.sda_m <= 1'b1;
            r_reg.sda_s <= 1'b1;
            r_reg.sda_d <= 1'b1;
            r_reg.smb   <= tal_pkg::TAL_SMB_IDLE;
            r_reg.cfg   <= `TAL_RST_BYTE;
            r_reg.fcm   <= `TAL_RST_BYTE;
            r_reg.lhl   <= `TAL_RST_HIGH_LIM;
            r_reg.rhl   <= `TAL_RST_HIGH_LIM;
            r_reg.rcl   <= `TAL_RST_HIGH_LIM;
            r_reg.rll   <= `TAL_RST_LOW_LIM;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    // data line only, no clock drive
    assign sda_out    = 1'b0;
    assign sda_oe_n   = !r_reg.drive;
    assign alert_out  = 1'b0;
    assign alert_oe_n = !r_reg.alert_drv;
    assign reg_rdata  = r_reg.rdata;

endmodule : tal_alert_top

// >>> hw/tal_params.svh
// constants of the temperature alert and alert-response block
`ifndef TAL_PARAMS_SVH
`define TAL_PARAMS_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define TAL_CLK_HZ          20000000
`define TAL_CONV_TIME_US    31250
`define TAL_TOUT_TIME_US    25000
`define TAL_CNT_W           24

// --------------------------------------------------------------
// smbus addresses
// --------------------------------------------------------------
`define TAL_ARA_ADDR        7'h0c
`define TAL_ADDR_LO         7'h18
`define TAL_ADDR_HI         7'h4e
`define TAL_BITS_BYTE       4'h8

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define TAL_OFF_CONFIG      4'h0
`define TAL_OFF_FCM         4'h1
`define TAL_OFF_STATUS      4'h2
`define TAL_OFF_RATE        4'h3
`define TAL_OFF_LHL         4'h4
`define TAL_OFF_RHL         4'h5
`define TAL_OFF_RLL         4'h6
`define TAL_OFF_RCL         4'h7
`define TAL_OFF_LT          4'h8
`define TAL_OFF_RT          4'h9

// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define TAL_CFG_MASK_BIT    7
`define TAL_FCM_COMP_BIT    0
`define TAL_FCM_ARACFG_BIT  1
`define TAL_ST_BUSY_BIT     7
`define TAL_ST_LHIGH_BIT    6
`define TAL_ST_RHIGH_BIT    4
`define TAL_ST_RLOW_BIT     3
`define TAL_ST_OPEN_BIT     2
`define TAL_ST_RCRIT_BIT    1
`define TAL_ST_ALERT_BITS   8'h5a
`define TAL_RATE_W          3
`define TAL_RST_BYTE        8'h00
`define TAL_RST_HIGH_LIM    8'h7f
`define TAL_RST_LOW_LIM     8'h80

`endif

// >>> hw/tal_pkg.sv
// types of the temperature alert and alert-response block
`include "tal_params.svh"

package tal_pkg;

    // smbus slave states
    typedef enum logic [2:0] {
        TAL_SMB_IDLE = 3'b000,
        TAL_SMB_ADDR = 3'b001,
        TAL_SMB_ACK  = 3'b010,
        TAL_SMB_SEND = 3'b011,
        TAL_SMB_NACK = 3'b100
    } tal_smb_t;

    // conversion sequencer state
    typedef struct packed {
        logic                  in_conv;
        logic [`TAL_CNT_W-1:0] cnt;
    } tal_seq_t;

    // alert block state
    typedef struct packed {
        logic                  scl_m;
        logic                  scl_s;
        logic                  scl_d;
        logic                  sda_m;
        logic                  sda_s;
        logic                  sda_d;
        logic                  a0_m;
        logic                  a0_s;
        tal_smb_t              smb;
        logic [7:0]            sh;
        logic [3:0]            bcnt;
        logic                  drive;
        logic [`TAL_CNT_W-1:0] tout;
        logic [7:0]            cfg;
        logic [7:0]            fcm;
        logic [7:0]            rate;
        logic [7:0]            lhl;
        logic [7:0]            rhl;
        logic [7:0]            rll;
        logic [7:0]            rcl;
        logic [7:0]            lt;
        logic [7:0]            rt;
        logic [7:0]            stat;
        logic [7:0]            cmp;
        logic [7:0]            rdata;
        logic                  alert_drv;
    } tal_main_t;

endpackage : tal_pkg

// >>> hw/tal_conv_seq.sv
// conversion sequencer: local then remote reading, then idle gap
`timescale 1ns/10ps
`include "tal_params.svh"

module tal_conv_seq #(
    parameter int CONV_CYCLES = `TAL_CONV_TIME_US * (`TAL_CLK_HZ / 1000000)
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // rate selection
    input  wire logic [`TAL_RATE_W-1:0] rate_code,
    // conversion events
    output logic                       local_done,
    output logic                       remote_done,
    output logic                       busy
);

    tal_pkg::tal_seq_t      s_reg;
    tal_pkg::tal_seq_t      s_next;
    logic [`TAL_CNT_W-1:0]  conv_last;
    logic [`TAL_CNT_W-1:0]  half_last;
    logic [`TAL_CNT_W-1:0]  idle_len;

    // fixed length, idle gap of rate-code conversion periods
    assign conv_last = `TAL_CNT_W'(CONV_CYCLES - 1);
    assign half_last = `TAL_CNT_W'(CONV_CYCLES / 2 - 1);
    assign idle_len  = `TAL_CNT_W'(rate_code) * `TAL_CNT_W'(CONV_CYCLES);

    assign local_done  = s_reg.in_conv && (s_reg.cnt == half_last);
    assign remote_done = s_reg.in_conv && (s_reg.cnt == conv_last);
    assign busy        = s_reg.in_conv;

    // next state
    always_comb
    begin
        s_next = s_reg;
        if (s_reg.in_conv)
        begin
            if (s_reg.cnt == conv_last)
            begin
                s_next.cnt     = '0;
                s_next.in_conv = (idle_len == '0);
            end
            else
            begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
        else if ((s_reg.cnt + 1'b1) >= idle_len)
        begin
            s_next.cnt     = '0;
            s_next.in_conv = 1'b1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.in_conv <= 1'b1;
            s_reg.cnt     <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule : tal_conv_seq

// >>> verification/tal_alert_assertions.sv
// assertions for the temperature alert block
`timescale 1ns/10ps
`include "tal_params.svh"

module tal_alert_checker #(
    parameter int CONV_CYCLES = 40,
    parameter int TOUT_CYCLES = 200
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // status and pins
    input wire logic       conv_busy,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       alert_out,
    input wire logic       alert_oe_n
);
    logic comp_reg;   // shadow of the comparator mode bit
    int   busy_reg, scl_lo_reg; // place in conversion, link clock low run
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // shadow and run-length counters
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comp_reg   <= 1'b0;
            busy_reg   <= 0;
            scl_lo_reg <= 0;
        end
        else
        begin
            if (reg_wr && reg_addr == `TAL_OFF_FCM)
                comp_reg <= reg_wdata[`TAL_FCM_COMP_BIT];
            busy_reg   <= conv_busy ? busy_reg % CONV_CYCLES + 1 : 0;
            scl_lo_reg <= scl_in ? 0 : scl_lo_reg + 1;
        end
    end
    sequence s_mask_wr;
        reg_wr && reg_addr == `TAL_OFF_CONFIG && reg_wdata[`TAL_CFG_MASK_BIT];
    endsequence
    sequence s_status_rd;
        reg_rd && reg_addr == `TAL_OFF_STATUS;
    endsequence
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0 && alert_out == 1'b0)
        else $error("open drain pin driven high");
    AST_MASK_WRITE: assert property (s_mask_wr |-> ##2 alert_oe_n)
        else $error("alert not released by mask");
    AST_STATUS_MASK: assert property (s_status_rd ##0 (!comp_reg && !alert_oe_n)
        |-> ##2 alert_oe_n)
        else $error("status read did not mask alert");
    AST_RESET_REL: assert property ($rose(rst_n) |-> alert_oe_n && sda_oe_n)
        else $error("pins not released after reset");
    AST_BUSY_LEN: assert property ($fell(conv_busy) |-> busy_reg == CONV_CYCLES)
        else $error("conversion length wrong");
    AST_SDA_FALL: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("data driven while clock high");
    AST_TIMEOUT: assert property (scl_lo_reg > TOUT_CYCLES + 8 |-> sda_oe_n)
        else $error("data held past bus timeout");
endmodule : tal_alert_checker

bind tal_alert_top tal_alert_checker #(.CONV_CYCLES(CONV_CYCLES), .TOUT_CYCLES(TOUT_CYCLES))
    u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_busy(conv_busy),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n));

// >>> verification/tal_host_model.sv
// smbus host model servicing alerts by alert response reads
`timescale 1ns/10ps
`include "tal_params.svh"

module tal_host_model (
    // clock and control
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [1:0] mode,
    // bus lines
    input  wire logic       sda_in,
    output logic            scl,
    output logic            sda_host,
    // results
    output logic            got_ack,
    output logic [7:0]      got_byte,
    output logic            done
);
    logic       s;
    logic [7:0] ara_byte = {`TAL_ARA_ADDR, 1'b1};
    // idle bus: clock stands high, data released
    initial
    begin
        scl      = 1'b1;
        sda_host = 1'b1;
        got_ack  = 1'b0;
        got_byte = 8'h00;
        done     = 1'b1;
    end
    // one link clock pulse, data set while low
    task automatic bit_io(input logic b, output logic r);
        #50 sda_host = b;
        #200 scl = 1'b1;
        #75 r = sda_in;
        #75 scl = 1'b0;
    endtask : bit_io
    always @(posedge ref_clk)
    begin
        if (go)
        begin
            done = 1'b0;
            #10 sda_host = 1'b0;
            #200 scl = 1'b0;
            for (int i = 7; i >= 0; i--)
                bit_io(ara_byte[i], s);
            bit_io(1'b1, s);
            got_ack = !s;
            if (mode == 2'h2)
                #15000;   // clock held low past timeout
            for (int i = 7; i >= 0; i--)
            begin
                bit_io(mode != 2'h1, s);   // mode 1 pulls data low to clash
                got_byte[i] = s;
            end
            bit_io(1'b1, s);
            #50 sda_host = 1'b0;
            #200 scl = 1'b1;
            #100 sda_host = 1'b1;
            done = 1'b1;
        end
    end
endmodule : tal_host_model

// >>> verification/tal_alert_top_bench.sv
// self-checking bench for the temperature alert block
`timescale 1ns/10ps
`include "tal_params.svh"

module tal_alert_top_bench;
    localparam int CONV = 40;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] ltemp = 8'h14;
    logic [7:0] rtemp = 8'h19;
    logic       fault = 1'b0;
    logic       sel = 1'b0;
    logic       go = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] reg_rdata, got_byte, d;
    logic       conv_busy, scl, sda_host, sda_bus, sda_out, sda_oe_n;
    logic       alert_out, alert_oe_n, got_ack, done;
    int         miscompares = 0;
    int         cmp_count = 0;
    logic [3:0] rofs [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [7:0] rval [7] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'h80, 8'h7f};
    logic [7:0] bad [4] = '{8'h0a, 8'h0a, 8'h1e, 8'h0a};
    logic [7:0] bits [4] = '{8'h40, 8'h10, 8'h08, 8'h02};

    assign sda_bus = sda_host & (sda_oe_n | sda_out);   // pulled-up data line
    always #25 ref_clk = ~ref_clk;

    tal_alert_top #(.CONV_CYCLES(CONV), .TOUT_CYCLES(200)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_temp_in(ltemp),
        .remote_temp_in(rtemp), .diode_fault_in(fault), .conv_busy(conv_busy),
        .slave_addr_select_pin(sel), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
    tal_host_model host (.ref_clk(ref_clk), .go(go), .mode(mode), .sda_in(sda_bus),
        .scl(scl), .sda_host(sda_host), .got_ack(got_ack), .got_byte(got_byte), .done(done));

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ca(input logic v);
        chk({7'h0, alert_oe_n}, {7'h0, v});
    endtask : ca
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rc
    task automatic wc;
        repeat (2 * CONV + 6) @(posedge ref_clk);
    endtask : wc
    task automatic ara(input logic [1:0] m);
        mode <= m;
        go   <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        for (int n = 0; n < 2000 && !done; n++)
            @(posedge ref_clk);
        if (!done)
        begin
            miscompares++;
            complete_run;
        end
    endtask : ara

    // main sequence
    initial
    begin
        int k;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int n = 0; n < 7; n++)
            rc(rofs[n], rval[n]);
        rc(4'hf, 8'h00);
        wc;
        rc(`TAL_OFF_LT, 8'h14);
        rc(`TAL_OFF_RT, 8'h19);
        wr(`TAL_OFF_LT, 8'h55);
        rc(`TAL_OFF_LT, 8'h14);
        wr(`TAL_OFF_RATE, 8'h01);
        @(negedge ref_clk);
        for (int n = 0; n < 200 && conv_busy; n++)
            @(negedge ref_clk);
        for (k = 0; k < 200 && !conv_busy; k++)
            @(negedge ref_clk);
        chk(8'(k), 8'(CONV));
        @(posedge ref_clk);
        wr(`TAL_OFF_RATE, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(rofs[i + 3], bad[i]);
            wc;
            ca(1'b0);
            rd(`TAL_OFF_STATUS, d);
            chk(d & `TAL_ST_ALERT_BITS, bits[i]);
            repeat (2) @(posedge ref_clk);
            ca(1'b1);
            rc(`TAL_OFF_CONFIG, 8'h80);
            wr(rofs[i + 3], rval[i + 3]);
            wc;
            rd(`TAL_OFF_STATUS, d);
            wr(`TAL_OFF_CONFIG, 8'h00);
            rd(`TAL_OFF_STATUS, d);
            chk(d & `TAL_ST_ALERT_BITS, 8'h00);
            ca(1'b1);
        end
        wr(`TAL_OFF_CONFIG, 8'h80);
        wr(`TAL_OFF_LHL, 8'h0a);
        wc;
        ca(1'b1);
        wr(`TAL_OFF_CONFIG, 8'h00);
        repeat (3) @(posedge ref_clk);
        ca(1'b0);
        for (int p = 0; p < 2; p++)
        begin
            sel <= !p[0];
            repeat (4) @(posedge ref_clk);
            ara(2'h0);
            chk({7'h0, got_ack}, 8'h01);
            chk(got_byte, p ? {`TAL_ADDR_LO, 1'b0} : {`TAL_ADDR_HI, 1'b0});
            ca(1'b1);
            rc(`TAL_OFF_CONFIG, 8'h80);
            rd(`TAL_OFF_STATUS, d);
            wr(`TAL_OFF_CONFIG, 8'h00);
            wc;
            ca(1'b0);
        end
        wr(`TAL_OFF_FCM, 8'h02);
        ara(2'h0);
        chk({7'h0, got_ack}, 8'h00);
        wr(`TAL_OFF_FCM, 8'h00);
        ara(2'h1);
        ca(1'b0);
        rc(`TAL_OFF_CONFIG, 8'h00);
        ara(2'h2);
        chk(got_byte, 8'hff);
        ca(1'b0);
        wr(`TAL_OFF_FCM, 8'h01);
        rd(`TAL_OFF_STATUS, d);
        repeat (3) @(posedge ref_clk);
        ca(1'b0);
        wr(`TAL_OFF_LHL, 8'h7f);
        wc;
        ca(1'b1);
        wr(`TAL_OFF_FCM, 8'h00);
        rd(`TAL_OFF_STATUS, d);
        wr(`TAL_OFF_CONFIG, 8'h00);
        fault <= 1'b1;
        wc;
        ca(1'b1);
        rd(`TAL_OFF_STATUS, d);
        chk(d & 8'h7f, 8'h04);
        complete_run;
    end
endmodule : tal_alert_top_bench
